/* rtl/cc_src_pkg.sv */
package cc_src_pkg;

  // cc line classification as reported by the analog comparators
  localparam logic [1:0] CC_OPEN = 2'h0;
  localparam logic [1:0] CC_RA = 2'h1;
  localparam logic [1:0] CC_RD = 2'h2;

  // register byte offsets
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  // control register fields
  localparam int CTRL_DRP = 0;
  localparam int CTRL_PREFER_SNK = 1;
  localparam int CTRL_PREFER_SRC = 2;
  localparam int CTRL_AUDIO = 3;
  localparam int CTRL_DEBUG = 4;
  localparam int CTRL_VCONN = 5;
  localparam int CTRL_GO_SNK = 6;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

  // status register fields
  localparam int STAT_STATE = 0;
  localparam int STAT_ORIENT = 8;
  localparam int STAT_VBUS = 9;
  localparam int STAT_VCONN1 = 10;
  localparam int STAT_VCONN2 = 11;
  localparam int STAT_PD_OK = 12;
  localparam int STAT_TARGET = 13;

  // interval timers
  localparam int TIMER_W = 24;
  localparam int T_DEBOUNCE = 0;
  localparam int T_TRY_DEBOUNCE = 1;
  localparam int T_TRY_PERIOD = 2;
  localparam int T_TRY_TIMEOUT = 3;
  localparam int T_TOGGLE = 4;
  localparam int T_DISCONNECT = 5;
  localparam int N_TIMERS = 6;

  typedef enum logic [7:0] {
    ST_UNATT_WAIT = 8'h01,
    ST_UNATT = 8'h02,
    ST_ATTACH_WAIT = 8'h04,
    ST_ATTACHED = 8'h08,
    ST_TRY = 8'h10,
    ST_AUDIO = 8'h20,
    ST_DEBUG = 8'h40,
    ST_SNK_SIDE = 8'h80
  } state_type;

  // sink-side state that the handoff asks the sink logic to enter
  typedef enum logic [1:0] {
    SNK_UNATTACHED = 2'h0,
    SNK_TRY_WAIT = 2'h1,
    SNK_TRY = 2'h2,
    SNK_ATTACHED = 2'h3
  } snk_target_type;

  typedef struct packed {
    logic [1:0] cc1;
    logic [1:0] cc2;
    logic vbus_safe0;
    logic vbus_safe5;
    logic vconn_low;
    logic cc_dis_low;
  } sense_type;

  typedef struct packed {
    logic rp1;
    logic rp2;
    logic rdch1;
    logic rdch2;
    logic rd;
    logic vconn1;
    logic vconn2;
    logic vbus;
  } drive_type;

  typedef struct packed {
    logic pr_swap_accept;
    logic vconn_swap_done;
    logic prs_to_src;
    logic prs_orient;
    logic src_req;
    logic try_src_req;
  } pd_event_type;

endpackage

/* rtl/interval_timers.sv */
module interval_timers #(
  parameter int NT = 6,
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [NT-1:0] run,
  input wire logic [NT-1:0][W-1:0] limit,
  output logic [NT-1:0] done
);

  typedef struct packed {
    logic [NT-1:0][W-1:0] cnt;
  } timer_state_type;

  timer_state_type r;
  timer_state_type next_r;

  // a counter restarts the moment its run condition drops
  always_comb begin
    next_r = r;
    for (int i = 0; i < NT; i++) begin
      if (!run[i]) begin
        next_r.cnt[i] = '0;
      end else if (r.cnt[i] != limit[i]) begin
        next_r.cnt[i] = r.cnt[i] + W'(1);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NT; i++) begin
      done[i] = run[i] && (r.cnt[i] == limit[i]);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

endmodule

/* rtl/cc_source_attach_fsm.sv */
// Summary of operation
// [RULE1] unattached wait keeps vbus, vconn off
// [RULE2] rp on live pin, rdch on discharged pin
// [RULE3] leave wait once vconn off, pin discharged
// [RULE4] unattached and attach wait: rp both, no power
// [RULE5] rd on either or ra on both: attach wait
// [RULE6] ra with open is cable only: stay
// [RULE7] drp toggles to sink after period or command
// [RULE8] one rd debounced, vbus safe0: attached
// [RULE9] both ra debounced: audio accessory
// [RULE10] both rd debounced, vbus safe0: debug accessory
// [RULE11] open or open plus ra: back to unattached
// [RULE12] sink-preferring drp goes to try sink instead
// [RULE13] orientation latched on entry, monitor that pin
// [RULE14] vbus on at entry, pd waits safe5
// [RULE15] vconn on the pin not reading rd
// [RULE16] power swap entry never newly enables vconn
// [RULE17] vconn swap toggles vconn supply
// [RULE18] open on monitored pin: wait or unattached
// [RULE19] drp detach: unattached sink or try wait
// [RULE20] exit drops vbus, vconn unless power swap
// [RULE21] power swap accepted: rd, vbus off, keep vconn
// [RULE22] try source: debounce, period or timeout exits
// [RULE23] interval counters restart when condition drops
module cc_source_attach_fsm #(
  parameter int CC_DEBOUNCE_CYC = 20000,
  parameter int TRY_DEBOUNCE_CYC = 2000,
  parameter int TRY_PERIOD_CYC = 20000,
  parameter int TRY_TIMEOUT_CYC = 40000,
  parameter int TOGGLE_SRC_CYC = 10000,
  parameter int DISCONNECT_CYC = 200
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cc_src_pkg::sense_type sense,
  input wire cc_src_pkg::pd_event_type pd_event,
  output cc_src_pkg::drive_type drive,
  output logic orientation,
  output logic pd_allowed,
  output logic snk_go,
  output cc_src_pkg::snk_target_type snk_target
);

  typedef struct packed {
    cc_src_pkg::sense_type sync1;
    cc_src_pkg::sense_type sync2;
    logic [3:0] pattern;
    cc_src_pkg::state_type st;
    logic orient;
    logic vconn_on;
    logic dis_cc2;
    logic vbus_on;
    logic pd_ok;
    logic snk_go;
    cc_src_pkg::snk_target_type target;
    logic [cc_src_pkg::CTRL_W-1:0] ctrl;
    logic go_snk;
    cc_src_pkg::drive_type drive;
    logic [31:0] prdata;
  } fsm_state_type;

  fsm_state_type r;
  fsm_state_type next_r;

  logic [cc_src_pkg::N_TIMERS-1:0] run;
  logic [cc_src_pkg::N_TIMERS-1:0] done;
  logic [cc_src_pkg::N_TIMERS-1:0][cc_src_pkg::TIMER_W-1:0] limit;

  logic [1:0] c1;
  logic [1:0] c2;
  logic [1:0] mon;
  logic one_rd;
  logic both_rd;
  logic any_rd;
  logic both_ra;
  logic both_open;
  logic open_ra;
  logic stable;
  logic drp;
  logic addr_ok;
  logic wr_en;
  logic rd_setup;
  logic [31:0] status;

  // only the second synchroniser stage is looked at
  assign c1 = r.sync2.cc1;
  assign c2 = r.sync2.cc2;
  assign mon = r.orient ? c2 : c1;
  assign one_rd = (c1 == cc_src_pkg::CC_RD) ^ (c2 == cc_src_pkg::CC_RD);
  assign both_rd = (c1 == cc_src_pkg::CC_RD) && (c2 == cc_src_pkg::CC_RD);
  assign any_rd = (c1 == cc_src_pkg::CC_RD) || (c2 == cc_src_pkg::CC_RD);
  assign both_ra = (c1 == cc_src_pkg::CC_RA) && (c2 == cc_src_pkg::CC_RA);
  assign both_open = (c1 == cc_src_pkg::CC_OPEN) &&
                     (c2 == cc_src_pkg::CC_OPEN);
  assign open_ra = ((c1 == cc_src_pkg::CC_OPEN) &&
                    (c2 == cc_src_pkg::CC_RA)) ||
                   ((c1 == cc_src_pkg::CC_RA) &&
                    (c2 == cc_src_pkg::CC_OPEN));
  assign stable = ({c1, c2} == r.pattern);
  assign drp = r.ctrl[cc_src_pkg::CTRL_DRP];

  // debounce measures an unchanged cc pattern, so any flicker restarts it
  always_comb begin
    run = '0;
    run[cc_src_pkg::T_DEBOUNCE] =
      ((r.st == cc_src_pkg::ST_ATTACH_WAIT) && stable) ||
      ((r.st == cc_src_pkg::ST_AUDIO) && both_open); // [RULE23]
    run[cc_src_pkg::T_TRY_DEBOUNCE] =
      (r.st == cc_src_pkg::ST_TRY) && one_rd && stable; // [RULE23]
    run[cc_src_pkg::T_TRY_PERIOD] = (r.st == cc_src_pkg::ST_TRY);
    run[cc_src_pkg::T_TRY_TIMEOUT] = (r.st == cc_src_pkg::ST_TRY);
    run[cc_src_pkg::T_TOGGLE] = (r.st == cc_src_pkg::ST_UNATT) && drp;
    run[cc_src_pkg::T_DISCONNECT] =
      (r.st == cc_src_pkg::ST_ATTACHED) &&
      (mon == cc_src_pkg::CC_OPEN); // [RULE23]
  end

  always_comb begin
    limit[cc_src_pkg::T_DEBOUNCE] =
      cc_src_pkg::TIMER_W'(CC_DEBOUNCE_CYC);
    limit[cc_src_pkg::T_TRY_DEBOUNCE] =
      cc_src_pkg::TIMER_W'(TRY_DEBOUNCE_CYC);
    limit[cc_src_pkg::T_TRY_PERIOD] =
      cc_src_pkg::TIMER_W'(TRY_PERIOD_CYC);
    limit[cc_src_pkg::T_TRY_TIMEOUT] =
      cc_src_pkg::TIMER_W'(TRY_TIMEOUT_CYC);
    limit[cc_src_pkg::T_TOGGLE] =
      cc_src_pkg::TIMER_W'(TOGGLE_SRC_CYC);
    limit[cc_src_pkg::T_DISCONNECT] =
      cc_src_pkg::TIMER_W'(DISCONNECT_CYC);
  end

  interval_timers #(
    .NT(cc_src_pkg::N_TIMERS),
    .W(cc_src_pkg::TIMER_W)
  ) timers (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .run(run),
    .limit(limit),
    .done(done)
  );

  assign addr_ok = (paddr == cc_src_pkg::CTRL_OFFSET) ||
                   (paddr == cc_src_pkg::STATUS_OFFSET);
  assign wr_en = psel && penable && pwrite && ce;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    status = '0;
    status[cc_src_pkg::STAT_STATE +: 8] = r.st;
    status[cc_src_pkg::STAT_ORIENT] = r.orient;
    status[cc_src_pkg::STAT_VBUS] = r.drive.vbus;
    status[cc_src_pkg::STAT_VCONN1] = r.drive.vconn1;
    status[cc_src_pkg::STAT_VCONN2] = r.drive.vconn2;
    status[cc_src_pkg::STAT_PD_OK] = r.pd_ok;
    status[cc_src_pkg::STAT_TARGET +: 2] = r.target;
  end

  always_comb begin
    next_r = r;
    next_r.sync1 = sense;
    next_r.sync2 = r.sync1;
    next_r.pattern = {c1, c2};
    next_r.snk_go = 1'b0;
    next_r.go_snk = 1'b0;

    // read data is caught in the setup cycle so the access needs no wait
    if (rd_setup) begin
      if (paddr == cc_src_pkg::CTRL_OFFSET) begin
        next_r.prdata = 32'(r.ctrl);
      end else if (paddr == cc_src_pkg::STATUS_OFFSET) begin
        next_r.prdata = status;
      end else begin
        next_r.prdata = 32'h00000000;
      end
    end
    if (wr_en && (paddr == cc_src_pkg::CTRL_OFFSET)) begin
      next_r.ctrl = pwdata[cc_src_pkg::CTRL_W-1:0];
      next_r.go_snk = pwdata[cc_src_pkg::CTRL_GO_SNK];
    end

    unique case (r.st)
      cc_src_pkg::ST_UNATT_WAIT: begin
        next_r.vbus_on = 1'b0; // [RULE1]
        next_r.vconn_on = 1'b0; // [RULE1]
        if (r.sync2.vconn_low && r.sync2.cc_dis_low) begin
          next_r.st = cc_src_pkg::ST_UNATT; // [RULE3]
        end
      end
      cc_src_pkg::ST_UNATT: begin
        next_r.vbus_on = 1'b0; // [RULE4]
        next_r.vconn_on = 1'b0; // [RULE4]
        // a lone ra against open is a bare cable and is not acted on
        if (any_rd || both_ra) begin
          next_r.st = cc_src_pkg::ST_ATTACH_WAIT; // [RULE5] [RULE6]
        end else if (drp && (done[cc_src_pkg::T_TOGGLE] || r.go_snk)) begin
          next_r.st = cc_src_pkg::ST_SNK_SIDE; // [RULE7]
          next_r.target = cc_src_pkg::SNK_UNATTACHED;
          next_r.snk_go = 1'b1;
        end
      end
      cc_src_pkg::ST_ATTACH_WAIT: begin
        if (both_open || open_ra) begin
          next_r.snk_go = drp; // [RULE11]
          next_r.target = cc_src_pkg::SNK_UNATTACHED;
          next_r.st = drp ? cc_src_pkg::ST_SNK_SIDE :
                            cc_src_pkg::ST_UNATT; // [RULE11]
        end else if (done[cc_src_pkg::T_DEBOUNCE]) begin
          if (one_rd && r.sync2.vbus_safe0) begin
            if (drp && r.ctrl[cc_src_pkg::CTRL_PREFER_SNK]) begin
              next_r.st = cc_src_pkg::ST_SNK_SIDE; // [RULE12]
              next_r.target = cc_src_pkg::SNK_TRY;
              next_r.snk_go = 1'b1;
            end else begin
              next_r.st = cc_src_pkg::ST_ATTACHED; // [RULE8]
              next_r.orient = (c2 == cc_src_pkg::CC_RD); // [RULE13]
              next_r.vbus_on = 1'b1; // [RULE14]
              next_r.vconn_on = r.ctrl[cc_src_pkg::CTRL_VCONN]; // [RULE15]
              next_r.pd_ok = 1'b0;
            end
          end else if (both_ra && r.ctrl[cc_src_pkg::CTRL_AUDIO]) begin
            next_r.st = cc_src_pkg::ST_AUDIO; // [RULE9]
          end else if (both_rd && r.sync2.vbus_safe0 &&
                       r.ctrl[cc_src_pkg::CTRL_DEBUG]) begin
            next_r.st = cc_src_pkg::ST_DEBUG; // [RULE10]
            next_r.vbus_on = 1'b1;
          end
        end
      end
      cc_src_pkg::ST_ATTACHED: begin
        next_r.vbus_on = 1'b1; // [RULE14]
        // pd messaging is held back until vbus has reached safe 5 V
        if (r.sync2.vbus_safe5) begin
          next_r.pd_ok = 1'b1; // [RULE14]
        end
        if (pd_event.vconn_swap_done) begin
          next_r.vconn_on = !r.vconn_on; // [RULE17]
        end
        if (pd_event.pr_swap_accept) begin
          next_r.st = cc_src_pkg::ST_SNK_SIDE; // [RULE21]
          next_r.target = cc_src_pkg::SNK_ATTACHED;
          next_r.snk_go = 1'b1;
          next_r.vbus_on = 1'b0; // [RULE20] [RULE21]
          next_r.pd_ok = 1'b0;
        end else if (done[cc_src_pkg::T_DISCONNECT]) begin
          next_r.vbus_on = 1'b0; // [RULE20]
          next_r.vconn_on = 1'b0; // [RULE20]
          next_r.pd_ok = 1'b0;
          if (drp) begin
            next_r.st = cc_src_pkg::ST_SNK_SIDE; // [RULE19]
            next_r.snk_go = 1'b1;
            next_r.target = r.ctrl[cc_src_pkg::CTRL_PREFER_SRC] ?
                            cc_src_pkg::SNK_TRY_WAIT :
                            cc_src_pkg::SNK_UNATTACHED; // [RULE19]
          end else if (r.vconn_on) begin
            next_r.st = cc_src_pkg::ST_UNATT_WAIT; // [RULE18]
            next_r.dis_cc2 = !r.orient; // [RULE2]
          end else begin
            next_r.st = cc_src_pkg::ST_UNATT; // [RULE18]
          end
        end
      end
      cc_src_pkg::ST_TRY: begin
        next_r.vbus_on = 1'b0;
        next_r.vconn_on = 1'b0;
        if (done[cc_src_pkg::T_TRY_DEBOUNCE]) begin
          next_r.st = cc_src_pkg::ST_ATTACHED; // [RULE22]
          next_r.orient = (c2 == cc_src_pkg::CC_RD); // [RULE13]
          next_r.vbus_on = 1'b1;
          next_r.vconn_on = r.ctrl[cc_src_pkg::CTRL_VCONN]; // [RULE15]
          next_r.pd_ok = 1'b0;
        end else if (!any_rd &&
                     ((done[cc_src_pkg::T_TRY_PERIOD] &&
                       r.sync2.vbus_safe0) ||
                      done[cc_src_pkg::T_TRY_TIMEOUT])) begin
          next_r.st = cc_src_pkg::ST_SNK_SIDE; // [RULE22]
          next_r.target = cc_src_pkg::SNK_TRY_WAIT;
          next_r.snk_go = 1'b1;
        end
      end
      cc_src_pkg::ST_AUDIO: begin
        if (done[cc_src_pkg::T_DEBOUNCE]) begin
          next_r.st = cc_src_pkg::ST_UNATT;
        end
      end
      cc_src_pkg::ST_DEBUG: begin
        next_r.vbus_on = 1'b1;
        if ((c1 == cc_src_pkg::CC_OPEN) || (c2 == cc_src_pkg::CC_OPEN)) begin
          next_r.vbus_on = 1'b0;
          next_r.snk_go = drp;
          next_r.target = cc_src_pkg::SNK_UNATTACHED;
          next_r.st = drp ? cc_src_pkg::ST_SNK_SIDE :
                            cc_src_pkg::ST_UNATT;
        end
      end
      cc_src_pkg::ST_SNK_SIDE: begin
        // vconn survives here only after a power swap; sink logic owns cc
        next_r.vbus_on = 1'b0;
        if (r.target != cc_src_pkg::SNK_ATTACHED) begin
          next_r.vconn_on = 1'b0;
        end
        if (pd_event.prs_to_src) begin
          next_r.st = cc_src_pkg::ST_ATTACHED; // [RULE13]
          next_r.orient = pd_event.prs_orient; // [RULE13]
          next_r.vbus_on = 1'b1; // [RULE14]
          next_r.pd_ok = 1'b0;
          next_r.vconn_on = r.vconn_on &&
                            (r.target == cc_src_pkg::SNK_ATTACHED); // [RULE16]
        end else if (pd_event.try_src_req) begin
          next_r.st = cc_src_pkg::ST_TRY;
          next_r.vconn_on = 1'b0;
        end else if (pd_event.src_req) begin
          next_r.st = cc_src_pkg::ST_UNATT;
          next_r.vconn_on = 1'b0;
        end
      end
      default: begin
        next_r.st = cc_src_pkg::ST_UNATT;
        next_r.vbus_on = 1'b0;
        next_r.vconn_on = 1'b0;
      end
    endcase

    // terminations follow the state being entered
    next_r.drive = '0;
    unique case (next_r.st)
      cc_src_pkg::ST_UNATT_WAIT: begin
        next_r.drive.rp1 = next_r.dis_cc2; // [RULE2]
        next_r.drive.rp2 = !next_r.dis_cc2; // [RULE2]
        next_r.drive.rdch1 = !next_r.dis_cc2; // [RULE2]
        next_r.drive.rdch2 = next_r.dis_cc2; // [RULE2]
      end
      cc_src_pkg::ST_ATTACHED: begin
        next_r.drive.rp1 = !next_r.orient; // [RULE13]
        next_r.drive.rp2 = next_r.orient; // [RULE13]
        next_r.drive.vconn1 = next_r.vconn_on && next_r.orient; // [RULE15]
        next_r.drive.vconn2 = next_r.vconn_on && !next_r.orient; // [RULE15]
      end
      cc_src_pkg::ST_SNK_SIDE: begin
        next_r.drive.rd = 1'b1; // [RULE21]
        next_r.drive.vconn1 = next_r.vconn_on && next_r.orient; // [RULE21]
        next_r.drive.vconn2 = next_r.vconn_on && !next_r.orient;
      end
      default: begin
        next_r.drive.rp1 = 1'b1; // [RULE4]
        next_r.drive.rp2 = 1'b1; // [RULE4]
      end
    endcase
    next_r.drive.vbus = next_r.vbus_on;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.st <= cc_src_pkg::ST_UNATT;
      r.ctrl <= cc_src_pkg::CTRL_RESET;
      r.target <= cc_src_pkg::SNK_UNATTACHED;
      r.drive.rp1 <= 1'b1;
      r.drive.rp2 <= 1'b1;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign pready = ce;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = r.prdata;
  assign drive = r.drive;
  assign orientation = r.orient;
  assign pd_allowed = r.pd_ok;
  assign snk_go = r.snk_go;
  assign snk_target = r.target;

endmodule

/* dv/cc_src_properties.sv */
module cc_src_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cc_src_pkg::sense_type sense,
  input wire cc_src_pkg::pd_event_type pd_event,
  input wire cc_src_pkg::drive_type drive,
  input wire logic orientation,
  input wire logic pd_allowed,
  input wire logic snk_go,
  input wire cc_src_pkg::snk_target_type snk_target
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic vc;
  assign vc = drive.vconn1 || drive.vconn2;

  property p_dark;
    drive.rdch1 || drive.rdch2 |-> !drive.vbus && !vc;
  endproperty
  a_dark: assert property (p_dark)
    else $error("power applied during discharge");
  property p_dis;
    drive.rdch1 || drive.rdch2 |->
      drive.rp1 != drive.rdch1 && drive.rp2 != drive.rdch2;
  endproperty
  a_dis: assert property (p_dis)
    else $error("rp and rdch not split across pins");
  // sense reaches the state register three edges after it settles
  property p_leave;
    $fell(drive.rdch1 || drive.rdch2) |->
      $past(sense.vconn_low, 3) && $past(sense.cc_dis_low, 3);
  endproperty
  a_leave: assert property (p_leave)
    else $error("discharge ended before pin was low");
  property p_rise;
    $rose(drive.vbus) |->
      $past(sense.vbus_safe0, 3) || $past(pd_event.prs_to_src);
  endproperty
  a_rise: assert property (p_rise)
    else $error("vbus enabled without safe zero");
  property p_pin;
    drive.vbus && drive.rp1 != drive.rp2 |-> drive.rp2 == orientation
      && !(orientation ? drive.vconn2 : drive.vconn1);
  endproperty
  a_pin: assert property (p_pin)
    else $error("rp or vconn on wrong pin");
  property p_pd;
    $rose(pd_allowed) |-> drive.vbus && $past(sense.vbus_safe5, 3);
  endproperty
  a_pd: assert property (p_pd)
    else $error("pd allowed before safe five volts");
  property p_back;
    $rose(drive.vbus) && $past(pd_event.prs_to_src) |-> vc == $past(vc);
  endproperty
  a_back: assert property (p_back)
    else $error("vconn changed on swap entry");
  property p_swap;
    pd_event.vconn_swap_done && drive.vbus && drive.rp1 != drive.rp2
      |=> vc != $past(vc);
  endproperty
  a_swap: assert property (p_swap)
    else $error("vconn swap did not toggle supply");
  property p_exit;
    snk_go && snk_target != cc_src_pkg::SNK_ATTACHED |->
      !drive.vbus && !vc;
  endproperty
  a_exit: assert property (p_exit)
    else $error("power left on at sink handoff");
  property p_keep;
    snk_go && snk_target == cc_src_pkg::SNK_ATTACHED |->
      drive.rd && !drive.vbus && vc == $past(vc);
  endproperty
  a_keep: assert property (p_keep)
    else $error("power swap handoff wrong");
endmodule

/* dv/cc_far_end.sv */
module cc_far_end (
  input wire logic clk,
  input wire logic [2:0] att,
  input wire logic slow,
  input wire cc_src_pkg::drive_type drive,
  output cc_src_pkg::sense_type sense
);
  logic [5:0] vlev = 6'h00;
  logic [5:0] stp;
  logic [3:0] dis = 4'h0;
  logic [3:0] ccs;
  assign stp = slow ? 6'h01 : 6'h0A;
  // pairs of cc codes; an empty pin floats to open against our rp
  always_comb begin
    case (att)
      3'h1: ccs = 4'h8;
      3'h2: ccs = 4'h2;
      3'h3: ccs = 4'h4;
      3'h4: ccs = 4'h5;
      3'h5: ccs = 4'hA;
      3'h6: ccs = 4'h9;
      default: ccs = 4'h0;
    endcase
  end
  initial sense = '0;
  // vbus ramps and drains; slow mode stretches both edges
  always @(posedge clk) begin
    if (drive.vbus) begin
      vlev <= (vlev + stp > 6'h28) ? 6'h28 : vlev + stp;
    end else begin
      vlev <= (vlev < stp) ? 6'h00 : vlev - stp;
    end
    if ((drive.rdch1 || drive.rdch2) && sense.vconn_low) begin
      dis <= (dis == 4'hF) ? dis : dis + 4'h1;
    end else begin
      dis <= 4'h0;
    end
    sense <= {ccs, vlev == 6'h00, vlev >= (slow ? 6'h28 : 6'h04),
      !(drive.vconn1 || drive.vconn2), dis >= (slow ? 4'hC : 4'h2)};
  end
endmodule

/* dv/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic err;
  logic [2:0] att = 3'h0;
  logic [2:0] p;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, e;
  logic [31:0] seed = 32'h000175E7;
  logic pready, pslverr, orientation, pd_allowed, snk_go;
  int n_errors = 0;
  int comparisons = 0;
  cc_src_pkg::sense_type sense;
  cc_src_pkg::drive_type drive;
  cc_src_pkg::pd_event_type pd_event = '0;
  cc_src_pkg::snk_target_type snk_target;

  always #2.5 clk = ~clk;

  cc_source_attach_fsm #(.CC_DEBOUNCE_CYC(8), .TRY_DEBOUNCE_CYC(4),
    .TRY_PERIOD_CYC(8), .TRY_TIMEOUT_CYC(16), .TOGGLE_SRC_CYC(200),
    .DISCONNECT_CYC(2)) dut_u (
    .clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense(sense),
    .pd_event(pd_event), .drive(drive), .orientation(orientation),
    .pd_allowed(pd_allowed), .snk_go(snk_go), .snk_target(snk_target));
  cc_far_end far_u (.clk(clk), .att(att), .slow(slow), .drive(drive),
    .sense(sense));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // status of an attached source: vconn sits on the unmonitored pin
  function automatic logic [31:0] exp_att(input logic [2:0] pin,
      input logic vc);
    logic o;
    o = (pin == 3'h2);
    return {20'h00000, vc & ~o, vc & o, 1'b1, o, 8'h08};
  endfunction

  task summarize;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a transfer that never completes
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task ctl(input logic [31:0] d);
    apb(1'b1, cc_src_pkg::CTRL_OFFSET, d);
  endtask
  // polls status; state changes land a few cycles after their cause
  task wt(input logic [31:0] m, input logic [31:0] v);
    int i;
    i = 0;
    do begin
      apb(1'b0, cc_src_pkg::STATUS_OFFSET, 32'h0);
      i++;
    end while ((q & m) !== v && i < 300);
    chk(q & m, v);
  endtask
  task pls(input logic [5:0] v);
    @(posedge clk);
    pd_event <= v;
    @(posedge clk);
    pd_event <= '0;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, cc_src_pkg::CTRL_OFFSET, 32'h0);
    chk(q, 32'h0);
    wt(32'hFFFFFFFF, 32'h02);
    chk({24'h000000, drive}, 32'hC0);
    apb(1'b0, 12'h008, 32'h0);
    chk({q[30:0], err}, 32'h1);
    att <= 3'h3;
    repeat (40) @(posedge clk);
    wt(32'hFF, 32'h02);
    att <= 3'h4;
    wt(32'hFF, 32'h04);
    att <= 3'h3;
    wt(32'hFF, 32'h02);
    ctl(32'h08);
    att <= 3'h4;
    wt(32'hFF, 32'h20);
    att <= 3'h0;
    wt(32'hFF, 32'h02);
    ctl(32'h10);
    att <= 3'h5;
    wt(32'h2FF, 32'h240);
    att <= 3'h0;
    wt(32'hFF, 32'h02);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      p = seed[1] ? 3'h2 : (seed[0] ? 3'h6 : 3'h1);
      slow <= seed[5];
      ctl({26'h0, seed[4], 5'h00});
      att <= p;
      e = exp_att(p, seed[4]);
      wt(32'hFFF, e);
      chk({31'h0, orientation}, {31'h0, p == 3'h2});
      wt(32'h1000, 32'h1000);
      pls(6'h10);
      wt(32'hC00, exp_att(p, ~seed[4]) & 32'hC00);
      att <= 3'h0;
      // the wait state outlasts one poll, so it is seen at either speed
      if (!seed[4]) wt(32'hFF, 32'h01);
      wt(32'hFF, 32'h02);
    end
    slow <= 1'b0;
    ctl(32'h01);
    wt(32'h60FF, 32'h80);
    // directed handoff lands long before the toggle period runs out
    pls(6'h02);
    ctl(32'h41);
    apb(1'b0, cc_src_pkg::STATUS_OFFSET, 32'h0);
    chk(q & 32'h60FF, 32'h80);
    att <= 3'h1;
    ctl(32'h03);
    pls(6'h02);
    wt(32'h60FF, 32'h4080);
    pls(6'h08);
    wt(32'hFFF, 32'h208);
    pls(6'h10);
    wt(32'hC00, 32'h800);
    pls(6'h20);
    wt(32'h6AFF, 32'h6880);
    pls(6'h08);
    wt(32'hFFF, 32'hA08);
    ctl(32'h25);
    // detach while frozen: nothing may move until the enable returns
    ce <= 1'b0;
    att <= 3'h0;
    repeat (20) @(posedge clk);
    chk({24'h000000, drive}, 32'h83);
    ce <= 1'b1;
    wt(32'h6CFF, 32'h2080);
    pls(6'h01);
    wt(32'hFF, 32'h10);
    wt(32'h60FF, 32'h2080);
    att <= 3'h2;
    pls(6'h01);
    wt(32'hFFF, exp_att(3'h2, 1'b1));
    summarize();
  end
endmodule

bind cc_source_attach_fsm cc_src_checker chk_u (.clk(clk), .nrst(nrst),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sense(sense), .pd_event(pd_event), .drive(drive),
  .orientation(orientation), .pd_allowed(pd_allowed), .snk_go(snk_go),
  .snk_target(snk_target));
